// ===== timer_channel.sv
`default_nettype none
module timer_channel
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  timer_link_if.chan lk,
  input wire logic [7:0] mode,
  input wire logic cmp_write,
  input wire logic [7:0] cmp_wdata,
  output logic [7:0] cmp_read,
  output logic [7:0] count_out,
  output logic irq,
  output logic pin
);
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] cmp_active;
    logic [7:0] cmp_written;
    logic pend;
    logic late;
    logic ff;
    logic irq;
    logic pin;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;
  logic pwm;
  logic act_level;
  logic [7:0] inc;
  logic [7:0] new_cmp;

  assign pwm = mode[MODE_PWM_BIT];
  assign act_level = ~mode[MODE_ACT_BIT];
  assign inc = st.count + 8'h01;

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    next_st.irq = 1'b0;
    new_cmp = st.cmp_active;
    if (!lk.run)
    begin
      next_st.count = COUNT_RESET;
      // stopped pwm rests inactive
      if (pwm)
        next_st.ff = ~act_level;
      else if (mode[MODE_LVS_BIT] && !mode[MODE_LVR_BIT])
        next_st.ff = 1'b1;
      else if (mode[MODE_LVR_BIT] && !mode[MODE_LVS_BIT])
        next_st.ff = 1'b0;
    end
    else if (lk.clear)
    begin
      next_st.count = COUNT_RESET;
      next_st.irq = lk.clear_irq;
      if (mode[MODE_ACT_BIT])
        next_st.ff = ~st.ff;
    end
    else if (lk.tick)
    begin
      if (pwm)
      begin
        next_st.count = inc;
        if (st.count == COUNT_MAX)
        begin
          if (st.pend && !st.late)
          begin
            new_cmp = st.cmp_written;
            next_st.pend = 1'b0;
          end
          else if (st.pend)
            next_st.late = 1'b0;
        end
        next_st.cmp_active = new_cmp;
        // active at overflow, off at match
        if (inc == new_cmp)
          next_st.ff = ~act_level;
        else if (st.count == COUNT_MAX)
          next_st.ff = act_level;
      end
      else if (lk.cascade)
      begin
        next_st.count = inc;
        // upper byte still flags its match
        next_st.irq = lk.entry_irq && (inc == st.cmp_active);
      end
      else if (st.count == st.cmp_active)
      begin
        next_st.count = COUNT_RESET;
        next_st.irq = 1'b1;
        if (mode[MODE_ACT_BIT])
          next_st.ff = ~st.ff;
      end
      else
        next_st.count = inc;
    end
    if (cmp_write)
    begin
      next_st.cmp_written = cmp_wdata;
      if (pwm && lk.run)
      begin
        next_st.pend = 1'b1;
        next_st.late = (st.count == COUNT_MAX) ||
                       (lk.tick && st.count == COUNT_PRE_MAX);
      end
      else
      begin
        next_st.cmp_active = cmp_wdata;
        next_st.pend = 1'b0;
        next_st.late = 1'b0;
      end
    end
    next_st.pin = mode[MODE_TOE_BIT] & next_st.ff;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign lk.count = st.count;
  assign lk.cmp = st.cmp_active;
  assign cmp_read = st.cmp_written;
  assign count_out = st.count;
  assign irq = st.irq;
  assign pin = st.pin;
endmodule
`default_nettype wire

// ===== timer_pkg.sv
`default_nettype none
package timer_pkg;
  // mode control field positions
  localparam int MODE_TOE_BIT = 0;
  localparam int MODE_ACT_BIT = 1;
  localparam int MODE_LVR_BIT = 2;
  localparam int MODE_LVS_BIT = 3;
  localparam int MODE_CASCADE_BIT = 4;
  localparam int MODE_PWM_BIT = 6;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_PRE_MAX = 8'hFE;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  // clock select codes; 2..7 pick clock/2^(sel-1)
  localparam logic [2:0] SEL_EVENT_RISE = 3'h0;
  localparam logic [2:0] SEL_EVENT_FALL = 3'h1;
  localparam int PRESCALE_W = 6;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 6'h00;
  localparam int CLOCK_PERIOD_NS = 4;
  // count clock phases must exceed two system clocks while reading
  localparam int READ_PHASE_MIN_CYCLES = 2;
endpackage
`default_nettype wire

// ===== timer_link_if.sv
`default_nettype none
interface timer_link_if;
  logic run;
  logic tick;
  logic clear;
  logic clear_irq;
  logic cascade;
  logic entry_irq;
  logic [7:0] count;
  logic [7:0] cmp;
  modport ctl(output run, tick, clear, clear_irq, cascade, entry_irq,
              input count, cmp);
  modport chan(input run, tick, clear, clear_irq, cascade, entry_irq,
               output count, cmp);
endinterface
`default_nettype wire

// ===== cascaded_dual_8bit_timer.sv
`default_nettype none
module cascaded_dual_8bit_timer
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] low_timer_mode_control,
  input wire logic [7:0] high_timer_mode_control,
  input wire logic [2:0] low_clock_select,
  input wire logic [2:0] high_clock_select,
  input wire logic low_count_enable,
  input wire logic high_count_enable,
  input wire logic low_event_input_pin,
  input wire logic high_event_input_pin,
  input wire logic low_compare_write,
  input wire logic [7:0] low_compare_wdata,
  input wire logic high_compare_write,
  input wire logic [7:0] high_compare_wdata,
  input wire logic low_count_read,
  input wire logic high_count_read,
  output logic [7:0] low_compare_byte,
  output logic [7:0] high_compare_byte,
  output logic [7:0] low_count_byte,
  output logic [7:0] high_count_byte,
  output logic low_match_interrupt,
  output logic high_match_interrupt,
  output logic low_timer_output_pin,
  output logic high_timer_output_pin
);
  import timer_pkg::*;

  typedef struct packed {
    logic [timer_pkg::PRESCALE_W-1:0] presc;
    logic [1:0] evt_prev;
    logic [1:0] hold_pend;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  timer_link_if lo();
  timer_link_if hi();
  logic cascade;
  logic [1:0] raw;
  logic [1:0] read;
  logic [1:0] held_tick;
  logic match16;

  function automatic logic pick(input logic [2:0] sel,
                                input logic [PRESCALE_W-1:0] p,
                                input logic evt, input logic prev);
    logic hit;
    hit = 1'b0;
    if (sel == SEL_EVENT_RISE)
      hit = evt & ~prev;
    else if (sel == SEL_EVENT_FALL)
      hit = ~evt & prev;
    else
      hit = &(p | ~((PRESCALE_W'(1) << (sel - 3'h1)) - PRESCALE_W'(1)));
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////
  // cascade select
  assign cascade = high_timer_mode_control[MODE_CASCADE_BIT];
  assign read = {high_count_read, low_count_read};
  assign raw[0] = pick(low_clock_select, st.presc, low_event_input_pin,
                       st.evt_prev[0]);
  // upper clock select ignored in cascade
  assign raw[1] = cascade ? 1'b0 : pick(high_clock_select, st.presc,
                                        high_event_input_pin, st.evt_prev[1]);
  // a read holds the count edge until the read ends
  assign held_tick = (raw | st.hold_pend) & ~read;

  always_comb
  begin
    next_st.presc = st.presc + PRESCALE_W'(1);
    next_st.evt_prev = {high_event_input_pin, low_event_input_pin};
    next_st.hold_pend = (raw | st.hold_pend) & read;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // 16-bit match on the low count edge
  assign match16 = cascade && held_tick[0] && lo.run &&
                   lo.count == lo.cmp && hi.count == hi.cmp;

  assign lo.run = low_count_enable;
  assign lo.tick = held_tick[0];
  assign lo.clear = match16;
  assign lo.clear_irq = 1'b1;
  assign lo.cascade = cascade;
  assign lo.entry_irq = 1'b0;

  // lower enable runs and zeroes both
  assign hi.run = cascade ? low_count_enable : high_count_enable;
  // upper steps on each lower wrap
  assign hi.tick = cascade ? (held_tick[0] && lo.count == COUNT_MAX &&
                              !match16) : held_tick[1];
  assign hi.clear = match16;
  assign hi.clear_irq = 1'b0;
  assign hi.cascade = cascade;
  assign hi.entry_irq = 1'b1;

  timer_channel u_low (
    .clock(clock),
    .srst(srst),
    .lk(lo),
    .mode(low_timer_mode_control),
    .cmp_write(low_compare_write),
    .cmp_wdata(low_compare_wdata),
    .cmp_read(low_compare_byte),
    .count_out(low_count_byte),
    .irq(low_match_interrupt),
    .pin(low_timer_output_pin)
  );

  timer_channel u_high (
    .clock(clock),
    .srst(srst),
    .lk(hi),
    .mode(high_timer_mode_control),
    .cmp_write(high_compare_write),
    .cmp_wdata(high_compare_wdata),
    .cmp_read(high_compare_byte),
    .count_out(high_count_byte),
    .irq(high_match_interrupt),
    .pin(high_timer_output_pin)
  );
endmodule
`default_nettype wire

// ===== cascaded_dual_8bit_timer_asserts.sv
`default_nettype none
module cascaded_dual_8bit_timer_asserts
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] low_timer_mode_control,
  input wire logic [7:0] high_timer_mode_control,
  input wire logic low_count_enable,
  input wire logic low_compare_write,
  input wire logic [7:0] low_compare_wdata,
  input wire logic high_compare_write,
  input wire logic [7:0] high_compare_wdata,
  input wire logic low_count_read,
  input wire logic [7:0] low_compare_byte,
  input wire logic [7:0] high_compare_byte,
  input wire logic [7:0] low_count_byte,
  input wire logic [7:0] high_count_byte,
  input wire logic low_match_interrupt,
  input wire logic high_match_interrupt,
  input wire logic low_timer_output_pin
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  wire logic casc = high_timer_mode_control[MODE_CASCADE_BIT];
  wire logic pwm_on = low_timer_mode_control[MODE_PWM_BIT] &&
    low_timer_mode_control[MODE_TOE_BIT] && low_count_enable;
  ////////////////////////////////////////////////////////////////////////////
  sequence wrap_seq;
    $past(low_count_byte) == 8'hFF && low_count_byte == 8'h00;
  endsequence
  sequence active_seq;
    low_timer_output_pin == !low_timer_mode_control[MODE_ACT_BIT];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  low_readback_a: assert property (
    low_compare_write |=> low_compare_byte == $past(low_compare_wdata))
    else $error("low compare read-back wrong");
  high_readback_a: assert property (
    high_compare_write |=> high_compare_byte == $past(high_compare_wdata))
    else $error("high compare read-back wrong");
  match_clears_a: assert property (
    low_match_interrupt && !low_timer_mode_control[MODE_PWM_BIT]
    |-> low_count_byte == 8'h00)
    else $error("low count not cleared on match");
  cascade_clears_a: assert property (
    casc && low_match_interrupt |-> high_count_byte == 8'h00)
    else $error("high count not cleared on cascade match");
  stop_zeroes_a: assert property (
    casc && !low_count_enable |=> low_count_byte == 8'h00 &&
    high_count_byte == 8'h00)
    else $error("cascade stop did not zero counters");
  high_pulse_a: assert property (
    high_match_interrupt |=> !high_match_interrupt)
    else $error("high interrupt longer than one cycle");
  read_hold_a: assert property (
    low_count_read && low_count_enable |=> $stable(low_count_byte))
    else $error("count moved during read");
  pwm_rise_a: assert property (
    (pwm_on and wrap_seq) |-> ##[0:1] active_seq)
    else $error("pwm not active after overflow");
endmodule
bind cascaded_dual_8bit_timer cascaded_dual_8bit_timer_asserts chk_i (
  .clock(clock),
  .srst(srst),
  .low_timer_mode_control(low_timer_mode_control),
  .high_timer_mode_control(high_timer_mode_control),
  .low_count_enable(low_count_enable),
  .low_compare_write(low_compare_write),
  .low_compare_wdata(low_compare_wdata),
  .high_compare_write(high_compare_write),
  .high_compare_wdata(high_compare_wdata),
  .low_count_read(low_count_read),
  .low_compare_byte(low_compare_byte),
  .high_compare_byte(high_compare_byte),
  .low_count_byte(low_count_byte),
  .high_count_byte(high_count_byte),
  .low_match_interrupt(low_match_interrupt),
  .high_match_interrupt(high_match_interrupt),
  .low_timer_output_pin(low_timer_output_pin)
);
`default_nettype wire

// ===== cascaded_dual_8bit_timer_tb_top.sv
`default_nettype none
module cascaded_dual_8bit_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  localparam int CPT = 2;
  logic clock = 0, srst = 1, sel_hi = 0;
  logic [7:0] low_timer_mode_control = 8'h00, high_timer_mode_control = 8'h00;
  logic [7:0] low_compare_wdata = 8'h00, high_compare_wdata = 8'h00;
  logic [2:0] low_clock_select = 3'h2, high_clock_select = 3'h2;
  logic low_count_enable = 0, high_count_enable = 0, low_count_read = 0;
  logic low_event_input_pin = 0, high_event_input_pin = 0;
  logic low_compare_write = 0, high_compare_write = 0, high_count_read = 0;
  logic [7:0] low_compare_byte, high_compare_byte;
  logic [7:0] low_count_byte, high_count_byte;
  logic low_match_interrupt, high_match_interrupt;
  logic low_timer_output_pin, high_timer_output_pin;
  logic [15:0] v;
  int bad_count = 0, n_tests = 0;
  wire logic cur_irq = sel_hi ? high_match_interrupt : low_match_interrupt;
  cascaded_dual_8bit_timer dut (.*);
  initial forever #2 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task wr(input logic hi, input logic [7:0] d);
    low_compare_wdata = d;
    high_compare_wdata = d;
    high_compare_write = hi;
    low_compare_write = !hi;
    tick(1);
    high_compare_write = 0;
    low_compare_write = 0;
  endtask
  task wait_cnt(input logic [7:0] c);
    int i;
    i = 0;
    while (low_count_byte !== c && i < 2000)
    begin
      tick(1);
      i++;
    end
  endtask
  // active cycles over one whole pwm period
  task duty(input logic lvl, input logic [7:0] n);
    int act, tot;
    act = 0;
    tot = 0;
    wait_cnt(8'h01);
    do
    begin
      tick(1);
      tot++;
      if (low_timer_output_pin === lvl)
        act++;
    end while ((low_count_byte !== 8'h01 || tot < 3) && tot < 2000);
    chk(act[15:0], 16'(n * tot / 256));
  endtask
  task period(input logic [15:0] exp);
    int n;
    n = 0;
    tick(1);
    while (cur_irq !== 1'b1 && n < 2000)
    begin
      tick(1);
      n++;
    end
    n = 0;
    do
    begin
      tick(1);
      n++;
    end while (cur_irq !== 1'b1 && n < 2000);
    chk(n[15:0], exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #60000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    tick(2);
    srst = 0;
    chk({low_compare_byte, high_compare_byte}, 16'h0000);
    chk({low_count_byte, high_count_byte}, 16'h0000);
    low_timer_mode_control = 8'h41;
    wr(0, 8'h40);
    low_count_enable = 1;
    wait_cnt(8'h10);
    wr(0, 8'h80);
    chk(low_compare_byte, 8'h80);
    duty(1, 8'h80);
    wait_cnt(8'hFF);
    wr(0, 8'h20);
    chk(low_compare_byte, 8'h20);
    duty(1, 8'h80);
    duty(1, 8'h20);
    low_timer_mode_control = 8'h43;
    tick(4);
    duty(0, 8'h20);
    low_count_enable = 0;
    low_timer_mode_control = 8'h00;
    high_timer_mode_control = 8'h10;
    high_clock_select = 3'h7;
    tick(2);
    wr(0, 8'h02);
    tick(1);
    wr(1, 8'h01);
    high_count_enable = 1;
    tick(1);
    low_count_enable = 1;
    period(16'((16'h0102 + 1) * CPT));
    sel_hi = 1;
    period(16'((16'h0102 + 1) * CPT));
    sel_hi = 0;
    high_count_enable = 0;
    period(16'((16'h0102 + 1) * CPT));
    // reads need phases longer than two clocks
    low_clock_select = 3'h3;
    tick(8);
    low_count_read = 1;
    tick(1);
    v = {high_count_byte, low_count_byte};
    tick(4);
    chk({high_count_byte, low_count_byte}, v);
    low_count_read = 0;
    high_count_enable = 1;
    repeat (1100)
      if (high_count_byte !== 8'h01)
        tick(1);
    chk(high_count_byte, 8'h01);
    low_count_enable = 0;
    tick(2);
    chk({high_count_byte, low_count_byte}, 16'h0000);
    // upper timer alone, counting falling event edges
    high_count_enable = 0;
    high_timer_mode_control = 8'h03;
    high_clock_select = 3'h1;
    wr(1, 8'h02);
    high_count_enable = 1;
    repeat (3)
    begin
      high_event_input_pin = 1;
      tick(1);
      high_event_input_pin = 0;
      tick(1);
    end
    v = {high_count_byte, 6'h00, high_match_interrupt,
         high_timer_output_pin};
    chk(v, 16'h0003);
    high_count_enable = 0;
    tick(2);
    stop_test();
  end
endmodule
`default_nettype wire
